// [hdl/tpc_timer.sv]
// Timer top: 16-bit reload counter with comparator counter, single
// PWM and dual PWM modes, dead band and a reload interrupt pulse.
// Assumes software keeps the documented configuration order.
`timescale 1ns/100ps
`default_nettype none
module tpc_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire tpc_pkg::tpc_ctrl_t ctrl,
  input wire tpc_pkg::tpc_count_wr_t count_wr,
  input wire tpc_pkg::tpc_word_t reload_value,
  input wire tpc_pkg::tpc_word_t pwm_match,
  input wire logic [7:0] dead_band,
  input wire logic output_function_enable,
  input wire logic comparator_out,
  output tpc_pkg::tpc_word_t count,
  output logic timer_irq,
  output logic timer_out,
  output logic timer_out_complement,
  output logic input_pin_is_output
);
  import tpc_pkg::*;

  tpc_mode_t mode;
  logic comp_edge;
  logic [6:0] prescale_count;
  logic [6:0] next_prescale_count;
  logic [6:0] prescale_limit;
  logic tick;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic next_irq;
  logic out_level;
  logic next_out_level;
  logic was_enabled;
  logic pwm_mode;
  logic at_reload;
  logic dead_main;
  logic dead_comp;
  logic [7:0] dead_sat;

  // Mode decode from both control registers
  always_comb begin
    if (ctrl.mode_select_field == FIELD_COMPARATOR &&
        !ctrl.mode_select_extension) begin
      mode = TPC_MODE_COMPARATOR;
    end else if (ctrl.mode_select_field == FIELD_PWM) begin
      mode = ctrl.mode_select_extension ? TPC_MODE_PWM_DUAL :
                                           TPC_MODE_PWM_SINGLE;
    end else begin
      mode = TPC_MODE_IDLE;
    end
  end

  assign pwm_mode = (mode == TPC_MODE_PWM_SINGLE) ||
                    (mode == TPC_MODE_PWM_DUAL);

  // Edge choice follows polarity
  tpc_edge_detect edge_unit (
    .mclk(mclk),
    .reset(reset),
    .sig_in(comparator_out),
    .rising(ctrl.output_polarity_edge_select),
    .edge_seen(comp_edge)
  );

  // Prescale value is a power of two from 1 to 128
  assign prescale_limit = 7'((8'h01 << ctrl.prescale_log) - 8'h01);

  always_comb begin
    next_prescale_count = prescale_count;
    tick = 1'b0;
    if (ctrl.enable && pwm_mode) begin
      if (prescale_count >= prescale_limit) begin
        next_prescale_count = 7'h00;
        tick = 1'b1;
      end else begin
        next_prescale_count = prescale_count + 7'h01;
      end
    end else if (ctrl.enable && mode == TPC_MODE_COMPARATOR) begin
      tick = comp_edge;
    end
  end

  assign at_reload = (cnt == {reload_value.high, reload_value.low});

  // Count, interrupt and output level.
  always_comb begin
    next_cnt = cnt;
    next_irq = 1'b0;
    next_out_level = out_level;
    if (count_wr.write) begin
      // Start value covers only the first pass
      next_cnt = {count_wr.value.high, count_wr.value.low};
    end
    if (!ctrl.enable) begin
      // Idle: output follows polarity as initial level
      next_out_level = ctrl.output_polarity_edge_select;
    end else if (tick && !count_wr.write) begin
      if (at_reload) begin
        next_cnt = COUNT_RESTART;
        next_irq = 1'b1;
        if (mode == TPC_MODE_COMPARATOR) begin
          if (output_function_enable) begin
            next_out_level = ~out_level;
          end
        end else begin
          next_out_level = ctrl.output_polarity_edge_select;
        end
      end else begin
        if (cnt == COUNT_TOP) begin
          next_cnt = COUNT_WRAP;
        end else begin
          next_cnt = cnt + 16'h0001;
        end
        if (pwm_mode && (cnt == {pwm_match.high, pwm_match.low})) begin
          next_out_level = ~ctrl.output_polarity_edge_select;
        end
      end
    end
  end

  // Holding state when disabled needs no gating
  always_ff @(posedge mclk) begin
    if (reset) begin
      prescale_count <= 7'h00;
      cnt <= COUNT_RESTART;
      timer_irq <= 1'b0;
      out_level <= 1'b0;
      was_enabled <= 1'b0;
    end else begin
      prescale_count <= next_prescale_count;
      cnt <= next_cnt;
      timer_irq <= next_irq;
      out_level <= next_out_level;
      was_enabled <= ctrl.enable;
    end
  end

  // Dead band saturates at its top value
  assign dead_sat = (dead_band > DEAD_MAX) ? DEAD_MAX : dead_band;

  tpc_dead_band main_leg (
    .mclk(mclk),
    .reset(reset),
    .run(ctrl.enable || !was_enabled),
    .level_in(out_level),
    .delay(dead_sat),
    .level_out(dead_main)
  );

  tpc_dead_band comp_leg (
    .mclk(mclk),
    .reset(reset),
    .run(ctrl.enable || !was_enabled),
    .level_in(~out_level),
    .delay(dead_sat),
    .level_out(dead_comp)
  );

  // Output pins registered; dead band only in dual mode.
  always_ff @(posedge mclk) begin
    if (reset) begin
      count <= '0;
      timer_out <= 1'b0;
      timer_out_complement <= 1'b0;
      input_pin_is_output <= 1'b0;
    end else begin
      count <= tpc_word_t'(cnt);
      timer_out <= (mode == TPC_MODE_PWM_DUAL) ? dead_main : out_level;
      timer_out_complement <= (mode == TPC_MODE_PWM_DUAL) && dead_comp;
      input_pin_is_output <= (mode == TPC_MODE_PWM_DUAL);
    end
  end
endmodule
`default_nettype wire

// [hdl/tpc_pkg.sv]
// Package for the timer with PWM and comparator counter modes.
// Assumes one 20 MHz system clock and plain control ports, no bus.
package tpc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [15:0] COUNT_WRAP = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [7:0] DEAD_MAX = 8'h80;
  localparam logic [2:0] PRESCALE_MAX_LOG = 3'h7;

  // Mode field values; dual PWM uses the extension bit.
  localparam logic [2:0] FIELD_COMPARATOR = 3'h6;
  localparam logic [2:0] FIELD_PWM = 3'h3;

  typedef enum logic [1:0] {
    TPC_MODE_IDLE,
    TPC_MODE_COMPARATOR,
    TPC_MODE_PWM_SINGLE,
    TPC_MODE_PWM_DUAL
  } tpc_mode_t;

  // Control register zero and one fields gathered as one carrier.
  typedef struct packed {
    logic enable;
    logic [2:0] mode_select_field;
    logic mode_select_extension;
    logic output_polarity_edge_select;
    logic [2:0] prescale_log;
  } tpc_ctrl_t;

  // A 16-bit value split into its two byte registers.
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } tpc_word_t;

  // Count write: a strobe with the value written.
  typedef struct packed {
    logic write;
    tpc_word_t value;
  } tpc_count_wr_t;
endpackage

// [hdl/tpc_edge_detect.sv]
// Synchronised edge detector for the comparator output.
// Assumes the input is asynchronous and slower than a quarter of mclk.
`timescale 1ns/100ps
`default_nettype none
module tpc_edge_detect (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sig_in,
  input wire logic rising,
  output logic edge_seen
);
  logic sync_a;
  logic sync_b;
  logic prev;
  logic next_edge_seen;

  // Two sync stages plus history; first stage read only by the second.
  always_comb begin
    if (rising) begin
      next_edge_seen = sync_b & ~prev;
    end else begin
      next_edge_seen = ~sync_b & prev;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      prev <= 1'b0;
      edge_seen <= 1'b0;
    end else begin
      sync_a <= sig_in;
      sync_b <= sync_a;
      prev <= sync_b;
      edge_seen <= next_edge_seen;
    end
  end
endmodule
`default_nettype wire

// [hdl/tpc_dead_band.sv]
// Delays the low-to-high edge of one PWM leg by a dead-band count.
// Assumes the delay is shorter than both PWM phases.
`timescale 1ns/100ps
`default_nettype none
module tpc_dead_band (
  input wire logic mclk,
  input wire logic reset,
  input wire logic run,
  input wire logic level_in,
  input wire logic [7:0] delay,
  output logic level_out
);
  import tpc_pkg::*;
  logic [7:0] wait_count;
  logic [7:0] next_wait_count;
  logic next_level_out;

  always_comb begin
    next_wait_count = wait_count;
    next_level_out = level_out;
    if (run) begin
      if (!level_in) begin
        next_level_out = 1'b0;
        next_wait_count = 8'h00;
      end else if (!level_out) begin
        if (wait_count >= delay) begin
          next_level_out = 1'b1;
        end else begin
          next_wait_count = wait_count + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wait_count <= 8'h00;
      level_out <= 1'b0;
    end else begin
      wait_count <= next_wait_count;
      level_out <= next_level_out;
    end
  end
endmodule
`default_nettype wire

// [tb/tpc_comp_model.sv]
// Comparator model: a burst of whole pulses, idle low between bursts.
// Assumes the bench keeps half at two clocks or more.
`timescale 1ns/100ps
`default_nettype none
module tpc_comp_model (
  input wire logic mclk,
  input wire logic start,
  input wire logic [7:0] pulses,
  input wire logic [3:0] half,
  output logic comp_out
);
  int left = 0;
  int t = 0;
  initial comp_out = 1'b0;
  // The delay keeps the analog edge off the sampling edge.
  always @(posedge mclk) begin
    if (start) begin
      left = 2 * pulses;
      t = 0;
    end else if (left > 0) begin
      t++;
      if (t >= half) begin
        comp_out <= #7 ~comp_out;
        t = 0;
        left--;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tpc_timer_checker.sv]
// Checker for the timer top; bound to it in the bench.
// Assumes one clock domain and the synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_checker (
  input wire logic mclk,
  input wire logic reset,
  input wire tpc_pkg::tpc_ctrl_t ctrl,
  input wire tpc_pkg::tpc_count_wr_t count_wr,
  input wire tpc_pkg::tpc_word_t reload_value,
  input wire tpc_pkg::tpc_word_t pwm_match,
  input wire logic [7:0] dead_band,
  input wire logic output_function_enable,
  input wire logic comparator_out,
  input wire tpc_pkg::tpc_word_t count,
  input wire logic timer_irq,
  input wire logic timer_out,
  input wire logic timer_out_complement,
  input wire logic input_pin_is_output
);
  import tpc_pkg::*;
  logic dual;
  logic cmp;
  logic pwm_fast;
  assign dual = ctrl.mode_select_field == FIELD_PWM &&
                ctrl.mode_select_extension;
  assign cmp = ctrl.mode_select_field == FIELD_COMPARATOR &&
               !count_wr.write;
  assign pwm_fast = ctrl.enable && ctrl.mode_select_field == FIELD_PWM &&
                    ctrl.prescale_log == 3'h0 && !count_wr.write;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_dual_pin: assert property (
    !$past(reset) |-> input_pin_is_output == $past(dual))
    else $error("pin function does not follow dual mode");
  a_legs_apart: assert property (
    !(timer_out && timer_out_complement))
    else $error("both PWM legs high");
  a_comp_quiet: assert property (
    (!dual) [*4] |-> !timer_out_complement)
    else $error("complement high outside dual mode");
  a_hold_count: assert property (
    (!ctrl.enable && !count_wr.write) [*4] |-> $stable(count))
    else $error("count moved while disabled");
  a_irq_idle: assert property (
    (!ctrl.enable) [*4] |-> !timer_irq)
    else $error("interrupt while disabled");
  a_pwm_step: assert property (
    pwm_fast [*3] |=> count == $past(count) + 16'h0001 ||
      count == COUNT_RESTART || count == COUNT_WRAP)
    else $error("count did not step by one");
  a_comp_still: assert property (
    (cmp && $stable(comparator_out)) [*8] |-> $stable(count))
    else $error("count moved without a comparator edge");
  // A zero dead band lets one leg fall as the other rises.
  a_gap_comp: assert property (
    $rose(timer_out_complement) && dead_band != 8'h00 |->
      !$past(timer_out))
    else $error("no gap before complement rise");
  c_irq: cover property (timer_irq);
  c_dual: cover property (input_pin_is_output && timer_out_complement);
  c_cmp: cover property (cmp && timer_irq);
endmodule
`default_nettype wire

// [tb/tb_tpc_timer.sv]
// Bench for the timer: comparator counting, single and dual PWM.
// Assumes the comparator model and the checker files are compiled.
`timescale 1ns/100ps
`default_nettype none
module tb_tpc_timer;
  import tpc_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  tpc_ctrl_t ctrl = '0;
  tpc_count_wr_t count_wr = '0;
  tpc_word_t reload_value = 16'h0000;
  tpc_word_t pwm_match = 16'h0000;
  logic [7:0] dead_band = 8'h00;
  logic output_function_enable = 1'b1;
  logic comp_start = 1'b0;
  logic [7:0] comp_pulses = 8'h00;
  logic [3:0] comp_half = 4'h2;
  logic comparator_out, timer_irq, timer_out;
  logic timer_out_complement, input_pin_is_output;
  tpc_word_t count;
  int errors = 0, num_checks = 0, cyc = 0, irqs = 0, hi = 0, lo2 = 0;
  logic [31:0] seed = 32'h00006FBC;
  always #25 mclk = ~mclk;
  tpc_timer i_dut (.mclk, .reset, .ctrl, .count_wr, .reload_value,
    .pwm_match, .dead_band, .output_function_enable, .comparator_out,
    .count, .timer_irq, .timer_out, .timer_out_complement,
    .input_pin_is_output);
  tpc_comp_model i_comp (.mclk, .start(comp_start), .pulses(comp_pulses),
    .half(comp_half), .comp_out(comparator_out));
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    irqs <= irqs + timer_irq;
    hi <= hi + timer_out;
    lo2 <= lo2 + timer_out_complement;
  end
  function automatic int rnd(input int n);
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed % n;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic setup(input logic [2:0] f, input logic x, input logic pol,
      input logic [2:0] pl, input int s, input int r, input int m);
    @(posedge mclk);
    ctrl <= {1'b0, f, x, pol, pl};
    @(posedge mclk);
    count_wr <= {1'b1, s[15:0]};
    reload_value <= r[15:0];
    pwm_match <= m[15:0];
    @(posedge mclk);
    count_wr.write <= 1'b0;
    repeat (3) @(posedge mclk);
    ctrl.enable <= 1'b1;
  endtask
  task automatic wirq();
    for (int i = 0; i < 4000 && timer_irq !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
  endtask
  // Whole pulses are sent, so either edge choice sees n edges.
  task automatic comp_run(input logic pol);
    int r, c, k, n, i0;
    logic oe;
    r = 2 + rnd(4);
    c = 1 + rnd(r);
    n = 3 + rnd(8);
    oe = 1'(rnd(2));
    k = 0;
    output_function_enable <= oe;
    comp_half <= 4'(2 + rnd(3));
    setup(FIELD_COMPARATOR, 1'b0, pol, 3'h7, c, r, 0);
    i0 = irqs;
    for (int i = 0; i < n; i++) begin
      k += (c == r);
      c = (c == r) ? 1 : c + 1;
    end
    comp_pulses <= 8'(n);
    comp_start <= 1'b1;
    @(posedge mclk);
    comp_start <= 1'b0;
    repeat (n * 8 + 20) @(posedge mclk);
    check(count, c);
    check(irqs - i0, k);
    check(timer_out, pol ^ (oe & k[0]));
  endtask
  task automatic pwm_run(input logic x, input logic pol);
    int r, m, e, p, h, c0, h0, l0;
    r = 6 + rnd(10);
    m = 2 + rnd(r - 4);
    e = x ? rnd(3) : 0;
    p = 1 << {x, pol};
    h = (pol ? m : r - m) * p;
    dead_band <= 8'(e);
    setup(FIELD_PWM, x, pol, {1'b0, x, pol}, 1 + rnd(r), r, m);
    wirq();
    wirq();
    c0 = cyc;
    h0 = hi;
    l0 = lo2;
    repeat (3) wirq();
    check(cyc - c0, 3 * r * p);
    check(hi - h0, 3 * (h - e));
    check(lo2 - l0, x ? 3 * (r * p - h - e) : 0);
    check(input_pin_is_output, x);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 30000);
    errors++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    for (int q = 0; q < 2; q++) comp_run(q[0]);
    for (int q = 0; q < 4; q++) pwm_run(q[1], q[0]);
    test_done();
  end
endmodule
bind tpc_timer tpc_timer_checker i_chk (.mclk, .reset, .ctrl, .count_wr,
  .reload_value, .pwm_match, .dead_band, .output_function_enable,
  .comparator_out, .count, .timer_irq, .timer_out, .timer_out_complement,
  .input_pin_is_output);
`default_nettype wire
